// file: core/dsp_param_bank.sv
`default_nettype none
module dsp_param_bank #(
	parameter int unsigned TICK_CYCLES = dsp_pkg::TICK_CYCLES, // Cycles per 0.1 s
	parameter int unsigned FAN_UNIT_TICKS = dsp_pkg::FAN_UNIT_TICKS, // Ticks per fan unit
	parameter logic [15:0] FIRMWARE_CODE = 16'h0100 // Arbitrary release value
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic [15:0] req_addr_i,
	input wire logic [15:0] req_wdata_i,
	output logic ack_o,
	output logic [15:0] rdata_o,
	output logic [7:0] exc_o,
	input wire logic link_err_i,
	input wire logic link_ok_i,
	input wire logic fault_clear_i,
	input wire logic motor_start_i,
	input wire logic fan_demand_i,
	input wire logic alarm_event_i,
	input wire logic [15:0] alarm_code_i,
	input wire logic [15:0] drive_state_i,
	input wire logic [15:0] out_freq_i,
	input wire logic [15:0] motor_current_i,
	input wire logic [15:0] motor_voltage_i,
	input wire logic [15:0] bus_voltage_i,
	input wire logic [15:0] drive_temp_i,
	input wire logic [15:0] power_on_hours_i,
	input wire logic [15:0] run_hours_i,
	output logic freq_from_link_o,
	output logic run_from_link_o,
	output logic fan_on_o,
	output logic mock_alarm_o,
	output logic link_fault_alarm_o,
	output logic [7:0] station_o,
	output logic [15:0] bit_cycles_o,
	output logic [15:0] no_response_timeout_o,
	output logic [15:0] reply_interval_o
);
	import dsp_pkg::*;
	if (TICK_CYCLES < 1 || FAN_UNIT_TICKS < 1) begin : g_chk
		$error("tick counts must be at least one");
	end
	////////////////////////////////////////////////////////////////////////
	// Decoding helpers
	// Bit period in clock cycles for a rate code
	function automatic logic [15:0] rate_cycles(input logic [1:0] code);
		unique case (code)
			RATE_9600: rate_cycles = 16'(CLK_HZ / BPS_9600);
			RATE_19200: rate_cycles = 16'(CLK_HZ / BPS_19200);
			default: rate_cycles = 16'(CLK_HZ / BPS_38400);
		endcase
	endfunction : rate_cycles
	// Status group address
	function automatic logic is_status(input logic [15:0] a);
		is_status = (a >= ADR_STAT_FIRST) && (a <= ADR_STAT_LAST);
	endfunction : is_status
	// Writable address with a value it accepts
	function automatic logic legal_write(input logic [15:0] a, input logic [15:0] d);
		unique case (a)
			ADR_LINK_SRC: legal_write = d <= MAX_LINK_SRC;
			ADR_START_CNT, ADR_MOCK_ALARM: legal_write = 1'b1;
			ADR_FAN_CTRL: legal_write = d <= MAX_FAN_CTRL;
			ADR_FAN_TIME: legal_write = d <= MAX_FAN_TIME;
			ADR_STATION: legal_write = d >= MIN_STATION && d <= MAX_STATION;
			ADR_ERR_MODE: legal_write = d <= MAX_ERR_MODE;
			ADR_ERR_TIMER: legal_write = d <= MAX_ERR_TIMER;
			ADR_LINE_RATE: legal_write = d <= MAX_LINE_RATE;
			ADR_CHAR_LEN: legal_write = d == CHAR_LEN_8;
			ADR_PARITY: legal_write = d == PARITY_NONE;
			ADR_STOP_BIT: legal_write = d == STOP_ONE;
			ADR_NO_RESP: legal_write = d <= MAX_NO_RESP;
			ADR_REPLY_INT: legal_write = d <= MAX_REPLY_INT;
			default: legal_write = 1'b0;
		endcase
	endfunction : legal_write
	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops
	logic rst_q1; // First stage, read only by the second
	logic rst_n; // Released reset for the whole block
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Storage
	logic [15:0] link_source_select; // Source routing code
	logic [15:0] startup_counter; // Motor startups
	logic [15:0] mock_alarm_trigger; // Self-clearing trigger
	logic [15:0] fan_auto_control; // Fan mode
	logic [15:0] fan_run_time; // Fan hours / 10
	logic [15:0] station_number; // Link station
	logic [15:0] comm_error_handling; // Error mode
	logic [15:0] comm_error_timer; // Error window, 0.1 s
	logic [15:0] line_rate_select; // Rate code
	logic [15:0] no_response_timeout; // Seconds, 0 off
	logic [15:0] reply_interval; // 0.01 s units
	logic [15:0] alarm_hist [HIST_DEPTH]; // Newest first
	logic [31:0] tick_cnt; // Cycles within a tick
	logic tick; // One 0.1 s pulse
	logic wr_ok; // Accepted write this cycle
	logic fan_load; // Software load of fan time
	dsp_err_state_t err_state; // Error handler state
	assign wr_ok = req_i && req_write_i && legal_write(req_addr_i, req_wdata_i);
	assign fan_load = wr_ok && req_addr_i == ADR_FAN_TIME;
	////////////////////////////////////////////////////////////////////////
	// Time base
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (tick_cnt == TICK_CYCLES - 1);
			tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0 : tick_cnt + 32'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Settings written by the master
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_source_select <= RST_LINK_SRC;
			fan_auto_control <= RST_FAN_CTRL;
			station_number <= RST_STATION;
			comm_error_handling <= RST_ERR_MODE;
			comm_error_timer <= RST_ERR_TIMER;
			line_rate_select <= RST_LINE_RATE;
			no_response_timeout <= RST_NO_RESP;
			reply_interval <= RST_REPLY_INT;
		end
		else if (wr_ok)
		begin
			unique case (req_addr_i)
				ADR_LINK_SRC: link_source_select <= req_wdata_i;
				ADR_FAN_CTRL: fan_auto_control <= req_wdata_i;
				ADR_STATION: station_number <= req_wdata_i;
				ADR_ERR_MODE: comm_error_handling <= req_wdata_i;
				ADR_ERR_TIMER: comm_error_timer <= req_wdata_i;
				ADR_LINE_RATE: line_rate_select <= req_wdata_i;
				ADR_NO_RESP: no_response_timeout <= req_wdata_i;
				ADR_REPLY_INT: reply_interval <= req_wdata_i;
				default: ; // Fixed frame format and counters elsewhere
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Startup counter: a start in the write cycle still counts
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			startup_counter <= RST_START_CNT;
		else if (wr_ok && req_addr_i == ADR_START_CNT)
			startup_counter <= req_wdata_i + {15'h0, motor_start_i};
		else if (motor_start_i)
			startup_counter <= startup_counter + 16'h1;
	end
	////////////////////////////////////////////////////////////////////////
	// Mock alarm: one pulse, then the trigger reads back zero
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mock_alarm_trigger <= 16'h0;
			mock_alarm_o <= 1'b0;
		end
		else
		begin
			mock_alarm_o <= mock_alarm_trigger[0];
			if (wr_ok && req_addr_i == ADR_MOCK_ALARM)
				mock_alarm_trigger <= {15'h0, req_wdata_i[0]};
			else
				mock_alarm_trigger <= 16'h0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Alarm history, shifted on each new alarm
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < HIST_DEPTH; i++)
				alarm_hist[i] <= 16'h0;
		end
		else if (alarm_event_i)
		begin
			alarm_hist[0] <= alarm_code_i;
			for (int i = 1; i < HIST_DEPTH; i++)
				alarm_hist[i] <= alarm_hist[i - 1];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Fan run time and link error handling
	dsp_unit_counter #(
		.STEP_TICKS(FAN_UNIT_TICKS),
		.MAX_VALUE(MAX_FAN_TIME)
	) u_fan_time (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.tick_i(tick),
		.run_i(fan_on_o),
		.load_i(fan_load),
		.load_val_i(req_wdata_i),
		.value_o(fan_run_time)
	);
	dsp_comm_watch u_watch (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.tick_i(tick),
		.mode_i(comm_error_handling[1:0]),
		.limit_i(comm_error_timer),
		.err_i(link_err_i),
		.ok_i(link_ok_i),
		.clear_i(fault_clear_i),
		.trip_o(link_fault_alarm_o),
		.state_o(err_state)
	);
	////////////////////////////////////////////////////////////////////////
	// Outputs that steer the drive and the serial port
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			freq_from_link_o <= 1'b0;
			run_from_link_o <= 1'b0;
			fan_on_o <= 1'b1;
			station_o <= RST_STATION[7:0];
			bit_cycles_o <= rate_cycles(RST_LINE_RATE[1:0]);
			no_response_timeout_o <= RST_NO_RESP;
			reply_interval_o <= RST_REPLY_INT;
		end
		else
		begin
			freq_from_link_o <= link_source_select[0];
			run_from_link_o <= link_source_select[1];
			fan_on_o <= (fan_auto_control == 16'h0) ? 1'b1 : fan_demand_i;
			station_o <= station_number[7:0];
			bit_cycles_o <= rate_cycles(line_rate_select[1:0]);
			no_response_timeout_o <= no_response_timeout;
			reply_interval_o <= reply_interval;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Register answer, one cycle after the request
	logic [15:0] next_rdata; // Read value
	logic [7:0] next_exc; // Exception code
	always_comb
	begin
		next_rdata = 16'h0;
		next_exc = EXC_NONE;
		unique case (req_addr_i)
			ADR_LINK_SRC: next_rdata = link_source_select;
			ADR_START_CNT: next_rdata = startup_counter;
			ADR_MOCK_ALARM: next_rdata = mock_alarm_trigger;
			ADR_FAN_CTRL: next_rdata = fan_auto_control;
			ADR_FAN_TIME: next_rdata = fan_run_time;
			ADR_STATION: next_rdata = station_number;
			ADR_ERR_MODE: next_rdata = comm_error_handling;
			ADR_ERR_TIMER: next_rdata = comm_error_timer;
			ADR_LINE_RATE: next_rdata = line_rate_select;
			ADR_CHAR_LEN: next_rdata = CHAR_LEN_8;
			ADR_PARITY: next_rdata = PARITY_NONE;
			ADR_STOP_BIT: next_rdata = STOP_ONE;
			ADR_NO_RESP: next_rdata = no_response_timeout;
			ADR_REPLY_INT: next_rdata = reply_interval;
			ADR_STAT_FIRST: next_rdata = drive_state_i;
			ADR_ALARM_CODE: next_rdata = alarm_code_i;
			ADR_OUT_FREQ: next_rdata = out_freq_i;
			ADR_MOTOR_CUR: next_rdata = motor_current_i;
			ADR_MOTOR_VOLT: next_rdata = motor_voltage_i;
			ADR_BUS_VOLT: next_rdata = bus_voltage_i;
			ADR_DRIVE_TEMP: next_rdata = drive_temp_i;
			ADR_POWER_HOURS: next_rdata = power_on_hours_i;
			ADR_RUN_HOURS: next_rdata = run_hours_i;
			ADR_STATION_RB: next_rdata = station_number;
			ADR_LINK_STATUS: next_rdata = {14'h0, err_state};
			ADR_HIST_FIRST, ADR_HIST_SECOND, ADR_HIST_THIRD, ADR_HIST_LAST:
				next_rdata = alarm_hist[2'(req_addr_i - ADR_HIST_FIRST)];
			ADR_STAT_LAST: next_rdata = FIRMWARE_CODE;
			default: next_exc = EXC_ADDR;
		endcase
		// Writes to status are dropped silently; bad values refused
		if (req_write_i && !is_status(req_addr_i) && next_exc == EXC_NONE
			&& !legal_write(req_addr_i, req_wdata_i))
			next_exc = EXC_VALUE;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_o <= 1'b0;
			rdata_o <= 16'h0;
			exc_o <= EXC_NONE;
		end
		else
		begin
			ack_o <= req_i;
			rdata_o <= req_i ? next_rdata : 16'h0;
			exc_o <= req_i ? next_exc : EXC_NONE;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);
	a_src_route: assert property (##1 (freq_from_link_o == $past(link_source_select[0])
		&& run_from_link_o == $past(link_source_select[1])))
		else $error("source routing does not follow selector");
	a_start_count: assert property ((motor_start_i && !(req_i && req_write_i))
		|=> startup_counter == $past(startup_counter) + 16'h1)
		else $error("startup not counted");
	a_fan_forced: assert property ((fan_auto_control == 16'h0) |=> fan_on_o)
		else $error("fan off while forced on");
	a_fan_ceiling: assert property (fan_run_time <= MAX_FAN_TIME)
		else $error("fan run time above 9999");
	a_timer_range: assert property ((req_i && req_write_i && req_addr_i == ADR_ERR_TIMER
		&& req_wdata_i > MAX_ERR_TIMER) |=> (exc_o == EXC_VALUE
		&& comm_error_timer == $past(comm_error_timer)))
		else $error("error timer took an out-of-range value");
	a_rate_period: assert property ((line_rate_select == 16'h0) |=>
		bit_cycles_o == 16'(CLK_HZ / BPS_9600))
		else $error("bit period wrong for 9600");
	a_frame_fixed: assert property ((req_i && req_write_i && req_addr_i == ADR_PARITY
		&& req_wdata_i != PARITY_NONE) |=> (ack_o && exc_o == EXC_VALUE))
		else $error("unsupported parity accepted");
	a_status_ro: assert property ((req_i && req_write_i && is_status(req_addr_i))
		|=> (ack_o && exc_o == EXC_NONE && $stable(station_number)))
		else $error("status write not ignored");
endmodule : dsp_param_bank
`default_nettype wire

// file: core/dsp_pkg.sv
`default_nettype none
package dsp_pkg;
	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_HZ = 125_000_000; // Drive clock rate
	localparam int unsigned TICK_TIME_MS = 100; // Timer resolution, 0.1 s
	localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_TIME_MS; // Cycles per tick
	localparam int unsigned FAN_UNIT_HOURS = 10; // Fan run-time unit
	localparam int unsigned TICKS_PER_HOUR = 36000; // Ticks of 0.1 s per hour
	localparam int unsigned FAN_UNIT_TICKS = FAN_UNIT_HOURS * TICKS_PER_HOUR;
	localparam int unsigned HIST_DEPTH = 4; // Alarm history entries
	////////////////////////////////////////////////////////////////////////
	// Register addresses
	localparam logic [15:0] ADR_LINK_SRC = 16'h031c;
	localparam logic [15:0] ADR_START_CNT = 16'h031d;
	localparam logic [15:0] ADR_MOCK_ALARM = 16'h031e;
	localparam logic [15:0] ADR_FAN_CTRL = 16'h031f;
	localparam logic [15:0] ADR_FAN_TIME = 16'h0320;
	localparam logic [15:0] ADR_STATION = 16'h0401;
	localparam logic [15:0] ADR_ERR_MODE = 16'h0402;
	localparam logic [15:0] ADR_ERR_TIMER = 16'h0403;
	localparam logic [15:0] ADR_LINE_RATE = 16'h0404;
	localparam logic [15:0] ADR_CHAR_LEN = 16'h0405;
	localparam logic [15:0] ADR_PARITY = 16'h0406;
	localparam logic [15:0] ADR_STOP_BIT = 16'h0407;
	localparam logic [15:0] ADR_NO_RESP = 16'h0408;
	localparam logic [15:0] ADR_REPLY_INT = 16'h0409;
	localparam logic [15:0] ADR_STAT_FIRST = 16'h0501; // Drive state
	localparam logic [15:0] ADR_STAT_LAST = 16'h0510; // Firmware release
	localparam logic [15:0] ADR_HIST_FIRST = 16'h050c; // Newest alarm
	localparam logic [15:0] ADR_HIST_SECOND = 16'h050d;
	localparam logic [15:0] ADR_HIST_THIRD = 16'h050e;
	localparam logic [15:0] ADR_HIST_LAST = 16'h050f; // Oldest alarm
	localparam logic [15:0] ADR_ALARM_CODE = 16'h0502;
	localparam logic [15:0] ADR_OUT_FREQ = 16'h0503;
	localparam logic [15:0] ADR_MOTOR_CUR = 16'h0504;
	localparam logic [15:0] ADR_MOTOR_VOLT = 16'h0505;
	localparam logic [15:0] ADR_BUS_VOLT = 16'h0506;
	localparam logic [15:0] ADR_DRIVE_TEMP = 16'h0507;
	localparam logic [15:0] ADR_POWER_HOURS = 16'h0508;
	localparam logic [15:0] ADR_RUN_HOURS = 16'h0509;
	localparam logic [15:0] ADR_STATION_RB = 16'h050a; // Station readback
	localparam logic [15:0] ADR_LINK_STATUS = 16'h050b; // Error handler state
	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] RST_LINK_SRC = 16'h0000;
	localparam logic [15:0] RST_START_CNT = 16'h0000;
	localparam logic [15:0] RST_FAN_CTRL = 16'h0000;
	localparam logic [15:0] RST_FAN_TIME = 16'h0000;
	localparam logic [15:0] RST_STATION = 16'h0001;
	localparam logic [15:0] RST_ERR_MODE = 16'h0000;
	localparam logic [15:0] RST_ERR_TIMER = 16'h0014;
	localparam logic [15:0] RST_LINE_RATE = 16'h0001;
	localparam logic [15:0] RST_NO_RESP = 16'h0000;
	localparam logic [15:0] RST_REPLY_INT = 16'h0001;
	////////////////////////////////////////////////////////////////////////
	// Legal values
	localparam logic [15:0] MAX_LINK_SRC = 16'h0003;
	localparam logic [15:0] MAX_FAN_CTRL = 16'h0001;
	localparam logic [15:0] MAX_FAN_TIME = 16'h270f; // 9999 units
	localparam logic [15:0] MIN_STATION = 16'h0001;
	localparam logic [15:0] MAX_STATION = 16'h00ff;
	localparam logic [15:0] MAX_ERR_MODE = 16'h0003;
	localparam logic [15:0] MAX_ERR_TIMER = 16'h0258; // 60.0 s in ticks
	localparam logic [15:0] MAX_LINE_RATE = 16'h0002;
	localparam logic [15:0] CHAR_LEN_8 = 16'h0000; // Only 8 data bits
	localparam logic [15:0] PARITY_NONE = 16'h0003; // Only no parity
	localparam logic [15:0] STOP_ONE = 16'h0001; // Only one stop bit
	localparam logic [15:0] MAX_NO_RESP = 16'h003c;
	localparam logic [15:0] MAX_REPLY_INT = 16'h0064;
	////////////////////////////////////////////////////////////////////////
	// Line rates and link answers
	localparam logic [1:0] RATE_9600 = 2'h0;
	localparam logic [1:0] RATE_19200 = 2'h1;
	localparam int unsigned BPS_9600 = 9600;
	localparam int unsigned BPS_19200 = 19200;
	localparam int unsigned BPS_38400 = 38400;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ADDR = 8'h02; // Unmapped register
	localparam logic [7:0] EXC_VALUE = 8'h03; // Value out of range
	////////////////////////////////////////////////////////////////////////
	// Communication error handling
	localparam logic [1:0] MODE_TRIP_NOW = 2'h0;
	localparam logic [1:0] MODE_TRIP_LATER = 2'h1;
	localparam logic [1:0] MODE_RETRY = 2'h2;
	localparam logic [1:0] MODE_IGNORE = 2'h3;
	typedef enum logic [1:0] {
		ERR_IDLE = 2'b00,
		ERR_DELAY = 2'b01,
		ERR_RETRY = 2'b10,
		ERR_TRIP = 2'b11
	} dsp_err_state_t;
endpackage : dsp_pkg
`default_nettype wire

// file: core/dsp_unit_counter.sv
`default_nettype none
// Saturating run-time counter, one unit per STEP_TICKS ticks of running
module dsp_unit_counter #(
	parameter int unsigned STEP_TICKS = dsp_pkg::FAN_UNIT_TICKS,
	parameter logic [15:0] MAX_VALUE = dsp_pkg::MAX_FAN_TIME
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic load_i,
	input wire logic [15:0] load_val_i,
	output logic [15:0] value_o
);
	import dsp_pkg::*;
	if (STEP_TICKS < 1) begin : g_chk
		$error("STEP_TICKS must be at least one");
	end
	logic [31:0] part; // Ticks within the current unit
	////////////////////////////////////////////////////////////////////////
	// Partial unit, kept across stops
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			part <= 32'h0;
		else if (tick_i && run_i)
			part <= (part >= STEP_TICKS - 1) ? 32'h0 : part + 32'h1;
	end
	////////////////////////////////////////////////////////////////////////
	// Whole units; software load wins, count stops at the ceiling
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			value_o <= RST_FAN_TIME;
		else if (load_i)
			value_o <= load_val_i;
		else if (tick_i && run_i && part >= STEP_TICKS - 1 && value_o < MAX_VALUE)
			value_o <= value_o + 16'h1;
	end
	a_unit_ceiling: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!$past(load_i) && $past(value_o) >= MAX_VALUE) |-> value_o == $past(value_o))
		else $error("run-time counter passed its ceiling");
endmodule : dsp_unit_counter
`default_nettype wire

// file: core/dsp_comm_watch.sv
`default_nettype none
// Reaction to serial link errors: trip now, trip later, retry, or ignore
module dsp_comm_watch (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic [1:0] mode_i,
	input wire logic [15:0] limit_i,
	input wire logic err_i,
	input wire logic ok_i,
	input wire logic clear_i,
	output logic trip_o,
	output dsp_pkg::dsp_err_state_t state_o
);
	import dsp_pkg::*;
	dsp_err_state_t next_state; // Next handling state
	logic [15:0] elapsed; // Ticks since the error
	////////////////////////////////////////////////////////////////////////
	// State choice
	always_comb
	begin
		next_state = state_o;
		unique case (state_o)
			ERR_IDLE:
				if (err_i)
				begin
					unique case (mode_i)
						MODE_TRIP_NOW: next_state = ERR_TRIP;
						MODE_TRIP_LATER: next_state = ERR_DELAY;
						MODE_RETRY: next_state = ERR_RETRY;
						MODE_IGNORE: next_state = ERR_IDLE;
					endcase
				end
			ERR_DELAY:
				if (elapsed >= limit_i)
					next_state = ERR_TRIP;
			ERR_RETRY:
				if (ok_i)
					next_state = ERR_IDLE; // Retry succeeded
				else if (elapsed >= limit_i)
					next_state = ERR_TRIP;
			ERR_TRIP:
				if (clear_i && !(err_i && mode_i == MODE_TRIP_NOW))
					next_state = ERR_IDLE; // A fresh immediate trip wins over clear
		endcase
	end
	////////////////////////////////////////////////////////////////////////
	// State, trip flag and wait counter
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_o <= ERR_IDLE;
			trip_o <= 1'b0;
		end
		else
		begin
			state_o <= next_state;
			trip_o <= (next_state == ERR_TRIP);
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			elapsed <= 16'h0;
		else if (state_o == ERR_IDLE)
			elapsed <= 16'h0;
		else if (tick_i && elapsed != 16'hffff)
			elapsed <= elapsed + 16'h1;
	end
	a_trip_now: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_o == ERR_IDLE && err_i && mode_i == MODE_TRIP_NOW) |=> trip_o)
		else $error("immediate trip missing");
	a_ignore_err: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_o == ERR_IDLE && err_i && mode_i == MODE_IGNORE) |=> state_o == ERR_IDLE)
		else $error("ignore mode left idle");
	a_delay_trip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_o == ERR_DELAY && elapsed >= limit_i) |=> trip_o)
		else $error("delayed trip missing after timer");
	a_retry_ok: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_o == ERR_RETRY && ok_i) |=> (state_o == ERR_IDLE && !trip_o))
		else $error("successful retry did not resume");
endmodule : dsp_comm_watch
`default_nettype wire

// file: verification/dsp_link_master.sv
`default_nettype none
// Register master model: one request at a time, held for one clock, answer awaited up to three more clocks
module dsp_link_master (
	input wire logic clk_i,
	output logic req_o,
	output logic wr_o,
	output logic [15:0] addr_o,
	output logic [15:0] wdata_o,
	input wire logic ack_i,
	input wire logic [15:0] rdata_i,
	input wire logic [7:0] exc_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		req_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 16'h0000;
		wdata_o = 16'h0000;
	end
	// One word per request over the parallel request lines
	task acc(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] r, output logic [7:0] e);
		@(negedge clk_i);
		req_o = 1'b1;
		wr_o = w;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		req_o = 1'b0;
		for (int i = 0; i < 3 && ack_i !== 1'b1; i++)
			@(negedge clk_i);
		r = rdata_i;
		e = (ack_i === 1'b1) ? exc_i : 8'hff;
		// Released lines no longer show the old value
		addr_o = ~a;
		wdata_o = ~d;
	endtask : acc
endmodule : dsp_link_master
`default_nettype wire

// file: verification/dsp_param_bank_tb.sv
`default_nettype none
module dsp_param_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dsp_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic req, wr, ack, ferr, lok, fclr, mst, fdem, aev, flk, rlk, fan, mock, flt;
	logic [15:0] addr, wd, rd, sv, bitc, r, nrt, rpi;
	logic [7:0] exc, e, stn;
	int num_errors = 0;
	int checks_done = 0;
	always #4 ref_clk_i = ~ref_clk_i;
	dsp_link_master m_u (.clk_i(ref_clk_i), .req_o(req), .wr_o(wr), .addr_o(addr),
		.wdata_o(wd), .ack_i(ack), .rdata_i(rd), .exc_i(exc));
	dsp_param_bank #(.TICK_CYCLES(10), .FAN_UNIT_TICKS(3)) dut_u (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .req_i(req), .req_write_i(wr), .req_addr_i(addr),
		.req_wdata_i(wd), .ack_o(ack), .rdata_o(rd), .exc_o(exc), .link_err_i(ferr),
		.link_ok_i(lok), .fault_clear_i(fclr), .motor_start_i(mst), .fan_demand_i(fdem),
		.alarm_event_i(aev), .alarm_code_i(sv), .drive_state_i(sv), .out_freq_i(~sv),
		.motor_current_i(sv), .motor_voltage_i(sv), .bus_voltage_i(sv), .drive_temp_i(sv),
		.power_on_hours_i(sv), .run_hours_i(sv), .freq_from_link_o(flk),
		.run_from_link_o(rlk), .fan_on_o(fan), .mock_alarm_o(mock),
		.link_fault_alarm_o(flt), .station_o(stn), .bit_cycles_o(bitc),
		.no_response_timeout_o(nrt), .reply_interval_o(rpi));
	// Compare one value, count and report
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [15:0] a, input logic [15:0] d, input logic [7:0] ex);
		m_u.acc(1'b1, a, d, r, e);
		chk({8'h00, e}, {8'h00, ex});
	endtask : wr_reg
	task rd_reg(input logic [15:0] a, input logic [15:0] exp);
		m_u.acc(1'b0, a, 16'h0000, r, e);
		chk(r, exp);
	endtask : rd_reg
	task automatic pls(ref logic s);
		s = 1'b1;
		@(negedge ref_clk_i);
		s = 1'b0;
		@(negedge ref_clk_i);
	endtask : pls
	task nw(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : nw
	// Verdict and end of run
	task test_done;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	// Watchdog well beyond the expected run
	initial
	begin
		#100000;
		num_errors++;
		test_done();
	end
	// Main sequence
	initial
	begin
		{ferr, lok, fclr, mst, fdem, aev} = 6'h00;
		sv = 16'h1234;
		nw(3);
		rst_n_i = 1'b1;
		nw(3);
		rd_reg(ADR_LINE_RATE, 16'h0001);
		rd_reg(ADR_ERR_TIMER, 16'h0014);
		chk({15'h0000, fan}, 16'h0001);
		chk(nrt, RST_NO_RESP);
		chk(rpi, RST_REPLY_INT);
		chk({8'h00, stn}, RST_STATION);
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(ADR_LINK_SRC, i[15:0], EXC_NONE);
			nw(1);
			chk({14'h0000, rlk, flk}, i[15:0]);
		end
		wr_reg(ADR_LINK_SRC, 16'h0004, EXC_VALUE);
		rd_reg(ADR_LINK_SRC, 16'h0003);
		for (int i = 0; i < 3; i++)
		begin
			wr_reg(ADR_LINE_RATE, i[15:0], EXC_NONE);
			nw(1);
			chk(bitc, 16'd13020 >> i);
		end
		wr_reg(ADR_LINE_RATE, 16'h0003, EXC_VALUE);
		wr_reg(ADR_CHAR_LEN, 16'h0001, EXC_VALUE);
		wr_reg(ADR_PARITY, 16'h0000, EXC_VALUE);
		wr_reg(ADR_STOP_BIT, 16'h0002, EXC_VALUE);
		wr_reg(ADR_PARITY, 16'h0003, EXC_NONE);
		wr_reg(16'h0500, 16'h0000, EXC_ADDR);
		$display("link and frame tests done");
		wr_reg(ADR_FAN_CTRL, 16'h0001, EXC_NONE);
		nw(2);
		chk({15'h0000, fan}, 16'h0000);
		fdem = 1'b1;
		wr_reg(ADR_FAN_TIME, 16'h270e, EXC_NONE);
		wr_reg(ADR_FAN_TIME, 16'h2710, EXC_VALUE);
		nw(100);
		chk({15'h0000, fan}, 16'h0001);
		rd_reg(ADR_FAN_TIME, 16'h270f);
		wr_reg(ADR_START_CNT, 16'hfffe, EXC_NONE);
		pls(mst);
		pls(mst);
		rd_reg(ADR_START_CNT, 16'h0000);
		wr_reg(ADR_STAT_FIRST, 16'h0000, EXC_NONE);
		rd_reg(ADR_STAT_FIRST, 16'h1234);
		pls(aev);
		rd_reg(ADR_HIST_FIRST, 16'h1234);
		wr_reg(ADR_STATION, 16'h0005, EXC_NONE);
		wr_reg(ADR_STATION, 16'h0000, EXC_VALUE);
		chk({8'h00, stn}, 16'h0005);
		rd_reg(16'h050a, 16'h0005);
		wr_reg(ADR_MOCK_ALARM, 16'h0001, EXC_NONE);
		nw(1);
		chk({15'h0000, mock}, 16'h0001);
		rd_reg(ADR_MOCK_ALARM, 16'h0000);
		chk({15'h0000, mock}, 16'h0000);
		$display("counter and status tests done");
		pls(ferr);
		chk({15'h0000, flt}, 16'h0001);
		pls(fclr);
		wr_reg(ADR_ERR_MODE, 16'h0001, EXC_NONE);
		wr_reg(ADR_ERR_TIMER, 16'h0003, EXC_NONE);
		pls(ferr);
		nw(10);
		chk({15'h0000, flt}, 16'h0000);
		nw(40);
		chk({15'h0000, flt}, 16'h0001);
		pls(fclr);
		wr_reg(ADR_ERR_MODE, 16'h0002, EXC_NONE);
		pls(ferr);
		rd_reg(16'h050b, 16'h0002);
		pls(lok);
		rd_reg(16'h050b, 16'h0000);
		wr_reg(ADR_ERR_MODE, 16'h0003, EXC_NONE);
		pls(ferr);
		nw(50);
		chk({15'h0000, flt}, 16'h0000);
		wr_reg(ADR_ERR_TIMER, 16'h0259, EXC_VALUE);
		$display("link error tests done");
		test_done();
	end
endmodule : dsp_param_bank_tb
`default_nettype wire
